// file: modem_serial_flow_control.sv
// module: serial-side flow control of the radio modem toward the terminal
// Functional notes
// [RULE1] clear mode: cts drops in rx, tx end
// [RULE2] clear mode: cts drops when buffer near full
// [RULE3] buffer mode: cts drops only near full
// [RULE4] duty, always, rssi cts modes reserved
// [RULE5] cd on above threshold or transmitting
// [RULE6] cd absent when port two busy/differential
// [RULE7] rts ignore mode disregards rts
// [RULE8] rts flow: deliver only while rts high
// [RULE9] dtr low holds everything in reset
// [RULE10] dsr shows powered and operating
// [RULE11] pause: no txd edges for pause length
// [RULE12] end tx on empty buffer and pause
// [RULE13] command valid only after a pause
// [RULE14] address start char needs preceding pause
// [RULE15] pause length 3..255 chars, default 5
// [RULE16] pause from frame and baud, cap 170ms
// [RULE17] tx starts on data, preamble first, buffered
// [RULE18] keep sending until buffer drained
// [RULE19] 1kB buffer; overflow discards and restarts
// [RULE20] rx-time data buffered; tx after delay
// [RULE21] search only above signal threshold
// [RULE22] hold last rssi 7s then zero
// [RULE23] frame start, 7/8 data, parity, stops
// [RULE24] config sampled between transmissions
`timescale 1ns/1ns
`default_nettype none
module modem_serial_flow_control #(
	parameter int unsigned PAUSE_CAP = flow_pkg::PAUSE_CAP_CYC,
	parameter int unsigned RSSI_HOLD = flow_pkg::RSSI_HOLD_CYC,
	parameter int unsigned MS_CYC = flow_pkg::DELAY_MS_CYC,
	parameter int unsigned PRE_CYC = 1000
) (
	input wire logic clock,
	input wire logic rst_b,
	input wire logic dtr_pin,
	input wire logic txd_pin,
	input wire logic rts_pin,
	input wire flow_pkg::cfg_s cfg,
	input wire flow_pkg::port_s port,
	input wire logic rx_byte_valid,
	input wire logic [7:0] rx_byte,
	input wire logic radio_take,
	input wire logic radio_rx_busy,
	input wire logic [7:0] rssi,
	input wire logic rx_msg_done,
	input wire logic addr_char,
	input wire logic cmd_char,
	output logic cts,
	output logic cd,
	output logic cd_avail,
	output logic dsr,
	output logic tx_on,
	output logic preamble,
	output logic radio_valid,
	output logic deliver_ok,
	output logic search_en,
	output logic pause_seen,
	output logic cmd_valid,
	output logic addr_valid,
	output logic overflow,
	output logic [10:0] buf_level,
	output logic [7:0] last_rssi
);
	// ----------------------------------------
	// reset release; dtr low keeps the core in reset
	// ----------------------------------------
	logic [1:0] rst_sync_ff;
	logic [1:0] dtr_sync_ff, txd_sync_ff, rts_sync_ff;
	logic core_rst_b;
	always_ff @(posedge clock or negedge rst_b) begin
		if (!rst_b) rst_sync_ff <= 2'h0;
		else rst_sync_ff <= {rst_sync_ff[0], 1'b1};
	end
	// a floating dtr is expected to be pulled high at the board
	always_ff @(posedge clock or negedge rst_b) begin
		if (!rst_b) begin
			dtr_sync_ff <= 2'h3;
			txd_sync_ff <= 2'h3;
			rts_sync_ff <= 2'h0;
		end else begin
			dtr_sync_ff <= {dtr_sync_ff[0], dtr_pin};
			txd_sync_ff <= {txd_sync_ff[0], txd_pin};
			rts_sync_ff <= {rts_sync_ff[0], rts_pin};
		end
	end
	assign core_rst_b = rst_sync_ff[1] & dtr_sync_ff[1]; // [RULE9]
	assign dsr = core_rst_b; // [RULE10]

	// ----------------------------------------
	// configuration latched between transmissions
	// ----------------------------------------
	flow_pkg::cfg_s cfg_ff;
	logic [7:0] pause_clip;
	always_ff @(posedge clock or negedge core_rst_b) begin
		if (!core_rst_b) begin
			cfg_ff <= '0;
			cfg_ff.pause_chars <= flow_pkg::PAUSE_RST; // [RULE15]
			cfg_ff.char_bits <= flow_pkg::BITS_RST;
			cfg_ff.bit_cycles <= 16'h0001;
		end else if (!tx_on) begin
			cfg_ff <= cfg; // [RULE24]
		end
	end
	assign pause_clip = (cfg_ff.pause_chars < flow_pkg::PAUSE_MIN) ?
		flow_pkg::PAUSE_MIN : cfg_ff.pause_chars; // [RULE15]

	// ----------------------------------------
	// pause detection on txd
	// ----------------------------------------
	logic txd_prev_ff;
	logic txd_edge;
	logic [31:0] idle_cnt_ff;
	logic [31:0] char_cyc, pause_cyc;
	assign txd_edge = txd_prev_ff ^ txd_sync_ff[1];
	// one character is the whole frame: start, data, parity, stops
	assign char_cyc = 32'(cfg_ff.char_bits) * 32'(cfg_ff.bit_cycles); // [RULE23]
	assign pause_cyc = (32'(pause_clip) * char_cyc > 32'(PAUSE_CAP)) ?
		32'(PAUSE_CAP) : 32'(pause_clip) * char_cyc; // [RULE16]
	always_ff @(posedge clock or negedge core_rst_b) begin
		if (!core_rst_b) begin
			txd_prev_ff <= 1'b1;
			idle_cnt_ff <= 32'h0;
		end else begin
			txd_prev_ff <= txd_sync_ff[1];
			if (txd_edge) idle_cnt_ff <= 32'h0; // [RULE11]
			else if (idle_cnt_ff < pause_cyc) idle_cnt_ff <= idle_cnt_ff + 32'h1;
		end
	end
	assign pause_seen = (idle_cnt_ff >= pause_cyc); // [RULE11]
	// pause flag armed until the first character after it completes
	logic armed_ff;
	always_ff @(posedge clock or negedge core_rst_b) begin
		if (!core_rst_b) armed_ff <= 1'b0;
		else if (pause_seen) armed_ff <= 1'b1;
		else if (rx_byte_valid) armed_ff <= 1'b0;
	end
	assign cmd_valid = cmd_char & rx_byte_valid & armed_ff; // [RULE13]
	assign addr_valid = addr_char & rx_byte_valid & armed_ff; // [RULE14]

	// ----------------------------------------
	// transmit buffer, 1 kB
	// ----------------------------------------
	logic [7:0] mem [flow_pkg::BUF_BYTES];
	logic [9:0] wr_ptr_ff, rd_ptr_ff;
	logic [10:0] cnt_ff;
	logic do_wr, do_rd, full, near_full, empty;
	assign full = (cnt_ff == 11'(flow_pkg::BUF_BYTES));
	assign near_full = (cnt_ff >= 11'(flow_pkg::BUF_NEAR));
	assign empty = (cnt_ff == 11'h0);
	assign do_wr = rx_byte_valid & ~full;
	assign do_rd = radio_valid & radio_take;
	assign overflow = rx_byte_valid & full; // [RULE19]
	always_ff @(posedge clock) begin
		if (do_wr) mem[wr_ptr_ff] <= rx_byte; // [RULE17]
	end
	always_ff @(posedge clock or negedge core_rst_b) begin
		if (!core_rst_b) begin
			wr_ptr_ff <= 10'h0;
			rd_ptr_ff <= 10'h0;
			cnt_ff <= 11'h0;
		end else if (overflow) begin
			wr_ptr_ff <= 10'h0; // [RULE19]
			rd_ptr_ff <= 10'h0;
			cnt_ff <= 11'h0;
		end else begin
			if (do_wr) wr_ptr_ff <= wr_ptr_ff + 10'h1; // [RULE20]
			if (do_rd) rd_ptr_ff <= rd_ptr_ff + 10'h1;
			cnt_ff <= cnt_ff + 11'(do_wr) - 11'(do_rd);
		end
	end
	assign buf_level = cnt_ff;

	// ----------------------------------------
	// radio transmit state machine
	// ----------------------------------------
	typedef enum logic [3:0] {
		ST_IDLE = 4'h1,
		ST_DELAY = 4'h2,
		ST_PRE = 4'h4,
		ST_SEND = 4'h8
	} tx_state_e;
	tx_state_e state_ff;
	logic [31:0] tmr_ff;
	logic [31:0] delay_cyc;
	logic tx_end_ff;
	assign delay_cyc = 32'(cfg_ff.tx_delay_ms) * 32'(MS_CYC);
	always_ff @(posedge clock or negedge core_rst_b) begin
		if (!core_rst_b) begin
			state_ff <= ST_IDLE;
			tmr_ff <= 32'h0;
			tx_end_ff <= 1'b0;
		end else begin
			tx_end_ff <= 1'b0;
			unique case (state_ff)
				ST_IDLE: begin
					tmr_ff <= 32'h0;
					if (!empty && !radio_rx_busy) begin // [RULE20]
						state_ff <= (delay_cyc != 32'h0) ? ST_DELAY : ST_PRE;
					end
				end
				ST_DELAY: begin
					tmr_ff <= tmr_ff + 32'h1;
					if (tmr_ff + 32'h1 >= delay_cyc) begin // [RULE20]
						state_ff <= ST_PRE;
						tmr_ff <= 32'h0;
					end
				end
				ST_PRE: begin
					tmr_ff <= tmr_ff + 32'h1;
					if (tmr_ff + 32'h1 >= 32'(PRE_CYC)) state_ff <= ST_SEND; // [RULE17]
				end
				ST_SEND: begin
					if (overflow) begin
						state_ff <= ST_PRE; // [RULE19]
						tmr_ff <= 32'h0;
					end else if (empty && pause_seen) begin // [RULE12] [RULE18]
						state_ff <= ST_IDLE;
						tx_end_ff <= 1'b1;
					end
				end
			endcase
		end
	end
	assign tx_on = (state_ff == ST_PRE) || (state_ff == ST_SEND);
	assign preamble = (state_ff == ST_PRE);
	assign radio_valid = (state_ff == ST_SEND) && !empty;

	// ----------------------------------------
	// handshake outputs
	// ----------------------------------------
	logic cts_ff;
	always_ff @(posedge clock or negedge core_rst_b) begin
		if (!core_rst_b) cts_ff <= 1'b0;
		else begin
			unique case (cfg_ff.cts_mode)
				flow_pkg::CTS_CLEAR: // [RULE1] [RULE2]
					cts_ff <= !radio_rx_busy && !tx_end_ff && !near_full;
				flow_pkg::CTS_BUFFER:
					cts_ff <= !near_full; // [RULE3]
				default:
					cts_ff <= 1'b1; // [RULE4]
			endcase
		end
	end
	assign cts = cts_ff;
	assign search_en = (rssi > cfg_ff.sig_threshold); // [RULE21]
	assign cd_avail = !port.port2_data && !port.port2_diff; // [RULE6]
	always_ff @(posedge clock or negedge core_rst_b) begin
		if (!core_rst_b) cd <= 1'b0;
		else cd <= cd_avail && (search_en || tx_on); // [RULE5] [RULE6]
	end
	assign deliver_ok = (cfg_ff.rts_mode == flow_pkg::RTS_IGNORE) ? // [RULE7]
		1'b1 : rts_sync_ff[1]; // [RULE8]

	// ----------------------------------------
	// last received signal strength, held then cleared
	// ----------------------------------------
	logic [31:0] hold_ff;
	always_ff @(posedge clock or negedge core_rst_b) begin
		if (!core_rst_b) begin
			last_rssi <= 8'h00;
			hold_ff <= 32'h0;
		end else if (rx_msg_done) begin
			last_rssi <= rssi; // [RULE22]
			hold_ff <= 32'(RSSI_HOLD);
		end else if (hold_ff > 32'h1) begin
			hold_ff <= hold_ff - 32'h1;
		end else if (hold_ff == 32'h1) begin
			hold_ff <= 32'h0;
			last_rssi <= 8'h00; // [RULE22]
		end
	end

	// ----------------------------------------
	// checks
	// ----------------------------------------
	a_buffer_mode_cts: assert property (@(posedge clock) disable iff (!core_rst_b)
		(cfg_ff.cts_mode == flow_pkg::CTS_BUFFER && !near_full) |=> cts) // [RULE3]
		else $error("cts low in buffer mode without near full");
	a_clear_rx_cts: assert property (@(posedge clock) disable iff (!core_rst_b)
		(cfg_ff.cts_mode == flow_pkg::CTS_CLEAR && radio_rx_busy) |=> !cts) // [RULE1]
		else $error("cts high during reception");
	a_near_full_cts: assert property (@(posedge clock) disable iff (!core_rst_b)
		(cfg_ff.cts_mode == flow_pkg::CTS_CLEAR && near_full) |=> !cts) // [RULE2]
		else $error("cts high with buffer near full");
	a_cd_transmit: assert property (@(posedge clock) disable iff (!core_rst_b)
		(tx_on && cd_avail) |=> cd) // [RULE5]
		else $error("cd low while transmitting");
	a_cd_port2: assert property (@(posedge clock) disable iff (!core_rst_b)
		$past(port.port2_diff) |-> !cd) // [RULE6]
		else $error("cd driven with differential port two");
	a_tx_end_cond: assert property (@(posedge clock) disable iff (!core_rst_b)
		(state_ff == ST_SEND ##1 state_ff == ST_IDLE) |-> $past(empty)) // [RULE12]
		else $error("transmission ended with data left");
	sequence s_pre_start;
		state_ff == ST_IDLE ##1 state_ff == ST_PRE;
	endsequence
	a_preamble_first: assert property (@(posedge clock) disable iff (!core_rst_b)
		s_pre_start |-> !radio_valid) // [RULE17]
		else $error("data sent before preamble");
	a_overflow_flush: assert property (@(posedge clock) disable iff (!core_rst_b)
		overflow |=> (cnt_ff == 11'h0)) // [RULE19]
		else $error("buffer not flushed on overflow");
	a_cmd_needs_pause: assert property (@(posedge clock) disable iff (!core_rst_b)
		cmd_valid |-> armed_ff) // [RULE13]
		else $error("command accepted without pause");
	a_rts_ignore: assert property (@(posedge clock) disable iff (!core_rst_b)
		(cfg_ff.rts_mode == flow_pkg::RTS_IGNORE) |-> deliver_ok) // [RULE7]
		else $error("rts not ignored");
endmodule
`default_nettype wire

// file: flow_pkg.sv
// package: constants and carriers for the modem serial flow control block
package flow_pkg;
	// ----------------------------------------
	// clock and timing
	// ----------------------------------------
	localparam int unsigned CLK_HZ = 50_000_000;
	localparam int unsigned PAUSE_CAP_MS = 170;
	localparam int unsigned PAUSE_CAP_CYC = PAUSE_CAP_MS * (CLK_HZ / 1000);
	localparam int unsigned RSSI_HOLD_S = 7;
	localparam int unsigned RSSI_HOLD_CYC = RSSI_HOLD_S * CLK_HZ;
	localparam int unsigned DELAY_MS_CYC = CLK_HZ / 1000;
	// ----------------------------------------
	// sizes and defaults
	// ----------------------------------------
	localparam int unsigned BUF_BYTES = 1024;
	localparam int unsigned BUF_NEAR = 960;
	localparam logic [7:0] PAUSE_MIN = 8'h03;
	localparam logic [7:0] PAUSE_MAX = 8'hFF;
	localparam logic [7:0] PAUSE_RST = 8'h05;
	localparam logic [3:0] BITS_RST = 4'hA;
	// ----------------------------------------
	// modes
	// ----------------------------------------
	localparam logic [2:0] CTS_CLEAR = 3'h0;
	localparam logic [2:0] CTS_BUFFER = 3'h1;
	localparam logic [2:0] CTS_DUTY = 3'h2;
	localparam logic [2:0] CTS_ALWAYS = 3'h3;
	localparam logic [2:0] CTS_RSSI = 3'h4;
	localparam logic RTS_IGNORE = 1'b0;
	localparam logic RTS_FLOW = 1'b1;

	typedef struct packed {
		logic [2:0] cts_mode;
		logic rts_mode;
		logic [7:0] pause_chars;
		logic [3:0] char_bits;
		logic [15:0] bit_cycles;
		logic [7:0] sig_threshold;
		logic [15:0] tx_delay_ms;
	} cfg_s;

	typedef struct packed {
		logic port2_data;
		logic port2_diff;
	} port_s;
endpackage

// file: terminal_model.sv
// model: terminal equipment sending framed characters
`timescale 1ns/1ns
`default_nettype none
module terminal_model (
	input wire logic clock,
	input wire logic [15:0] bit_cycles,
	output logic txd_pin,
	output logic rx_byte_valid,
	output logic [7:0] rx_byte,
	output logic cmd_char,
	output logic addr_char
);
	initial begin
		txd_pin = 1'b1;
		rx_byte_valid = 1'b0;
		rx_byte = 8'h00;
		cmd_char = 1'b0;
		addr_char = 1'b0;
	end
	// called at a falling edge; start low, data lsb first, one stop
	task automatic send(input logic [7:0] b, input logic c, input logic a);
		logic [9:0] frame;
		frame = {1'b1, b, 1'b0};
		for (int i = 0; i < 10; i++) begin
			txd_pin = frame[i];
			repeat (bit_cycles) @(negedge clock);
		end
		rx_byte = b;
		cmd_char = c;
		addr_char = a;
		rx_byte_valid = 1'b1;
		@(negedge clock);
		rx_byte_valid = 1'b0;
		// released data shows garbage, not the last byte
		rx_byte = ~b;
		cmd_char = 1'b0;
		addr_char = 1'b0;
	endtask
endmodule
`default_nettype wire

// file: tb_modem_serial_flow_control.sv
// testbench: flow control block against a terminal model
`timescale 1ns/1ns
`default_nettype none
module tb_modem_serial_flow_control;
	// ----------------------------------------
	// signals
	// ----------------------------------------
	logic clock = 1'b0;
	logic rst_b = 1'b0;
	logic dtr_pin = 1'b1;
	logic rts_pin = 1'b0;
	// clear mode, pause 5 chars of 10 bits at 2 cycles: 100 cycles
	flow_pkg::cfg_s cfg = {3'h0, 1'b0, 8'h05, 4'hA, 16'h0002, 8'h80, 16'h0000};
	flow_pkg::port_s port = '0;
	logic radio_take = 1'b0;
	logic radio_rx_busy = 1'b0;
	logic [7:0] rssi = 8'h00;
	logic rx_msg_done = 1'b0;
	logic txd_pin, rx_byte_valid, addr_char, cmd_char;
	logic [7:0] rx_byte, last_rssi;
	logic cts, cd, cd_avail, dsr, tx_on, preamble, radio_valid, deliver_ok;
	logic search_en, pause_seen, cmd_valid, addr_valid, overflow;
	logic [10:0] buf_level;
	logic [15:0] cmd_cnt = '0, adr_cnt = '0, ovf_cnt = '0;
	int errors = 0;
	int comparisons = 0;
	int cycles = 0;
	int n;
	always #10 clock = ~clock;
	modem_serial_flow_control #(.PAUSE_CAP(200), .RSSI_HOLD(50),
		.MS_CYC(4), .PRE_CYC(8)) u_modem_serial_flow_control (.clock, .rst_b,
		.dtr_pin, .txd_pin, .rts_pin, .cfg, .port, .rx_byte_valid, .rx_byte,
		.radio_take, .radio_rx_busy, .rssi, .rx_msg_done, .addr_char,
		.cmd_char, .cts, .cd, .cd_avail, .dsr, .tx_on, .preamble, .radio_valid,
		.deliver_ok, .search_en, .pause_seen, .cmd_valid, .addr_valid,
		.overflow, .buf_level, .last_rssi);
	terminal_model term (.clock, .bit_cycles(cfg.bit_cycles), .txd_pin,
		.rx_byte_valid, .rx_byte, .cmd_char, .addr_char);
	// ----------------------------------------
	// pulse counters and timeout
	// ----------------------------------------
	always @(posedge clock) begin
		if (cmd_valid === 1'b1) cmd_cnt <= cmd_cnt + 16'h0001;
		if (addr_valid === 1'b1) adr_cnt <= adr_cnt + 16'h0001;
		if (overflow === 1'b1) ovf_cnt <= ovf_cnt + 16'h0001;
		cycles++;
		if (cycles == 40000) begin
			errors++;
			conclude();
		end
	end
	// ----------------------------------------
	// tasks
	// ----------------------------------------
	task check(input logic [15:0] seen, input logic [15:0] exp);
		comparisons++;
		if (seen !== exp) begin
			errors++;
			$display("unexpected at %0t: seen %0h expected %0h", $time, seen, exp);
		end
	endtask
	task wait_idle;
		for (n = 0; n < 800 && tx_on !== 1'b0; n++) @(negedge clock);
	endtask
	task conclude;
		$display("comparisons %0d errors %0d", comparisons, errors);
		if (errors == 0 && comparisons > 0) $display("bench passed");
		else $display("bench failed");
		$finish;
	endtask
	// ----------------------------------------
	// tests
	// ----------------------------------------
	initial begin
		repeat (2) @(negedge clock);
		rst_b = 1'b1;
		repeat (110) @(negedge clock);
		check(dsr, 1);
		check(cts, 1);
		check(pause_seen, 1);
		radio_take = 1'b1;
		term.send(8'h43, 1'b1, 1'b0);
		// transmit starts the cycle after the first byte lands; cd is registered
		repeat (2) @(negedge clock);
		check(tx_on, 1);
		check(cd, 1);
		term.send(8'h55, 1'b1, 1'b0);
		wait_idle();
		check(tx_on, 0);
		check(buf_level, 0);
		check(cmd_cnt, 1);
		term.send(8'hA5, 1'b0, 1'b1);
		term.send(8'hA5, 1'b0, 1'b1);
		wait_idle();
		check(adr_cnt, 1);
		$display("burst test done");
		radio_rx_busy = 1'b1;
		repeat (2) @(negedge clock);
		check(cts, 0);
		for (int m = 1; m < 5; m++) begin
			cfg.cts_mode = m[2:0];
			repeat (2) @(negedge clock);
			check(cts, 1);
		end
		cfg.cts_mode = flow_pkg::CTS_CLEAR;
		radio_rx_busy = 1'b0;
		repeat (2) @(negedge clock);
		check(cts, 1);
		$display("cts test done");
		rssi = 8'h90;
		repeat (2) @(negedge clock);
		check(cd, 1);
		check(search_en, 1);
		port.port2_data = 1'b1;
		repeat (2) @(negedge clock);
		check({cd_avail, cd}, 0);
		port = 2'b01;
		repeat (2) @(negedge clock);
		check({cd_avail, cd}, 0);
		port = '0;
		rx_msg_done = 1'b1;
		@(negedge clock);
		rx_msg_done = 1'b0;
		rssi = 8'h00;
		@(negedge clock);
		check(last_rssi, 8'h90);
		// hold of 50 cycles: still held just before, zero just after
		repeat (46) @(negedge clock);
		check(last_rssi, 8'h90);
		repeat (9) @(negedge clock);
		check(last_rssi, 0);
		cfg.rts_mode = flow_pkg::RTS_FLOW;
		repeat (4) @(negedge clock);
		check(deliver_ok, 0);
		rts_pin = 1'b1;
		repeat (4) @(negedge clock);
		check(deliver_ok, 1);
		cfg.rts_mode = flow_pkg::RTS_IGNORE;
		rts_pin = 1'b0;
		repeat (4) @(negedge clock);
		check(deliver_ok, 1);
		$display("line test done");
		// byte held during reception, then delay, preamble; pause capped
		cfg.tx_delay_ms = 16'h0002;
		cfg.pause_chars = 8'hFF;
		radio_rx_busy = 1'b1;
		term.send(8'h3C, 1'b0, 1'b0);
		repeat (2) @(negedge clock);
		check({tx_on, buf_level}, 16'h0001);
		radio_rx_busy = 1'b0;
		// two ms of four cycles: eight cycles spent in delay
		repeat (5) @(negedge clock);
		check(tx_on, 1'b0);
		repeat (6) @(negedge clock);
		check({tx_on, preamble, radio_valid}, 16'h0006);
		// 255 chars would be 5100 cycles; the cap of 200 wins
		repeat (186) @(negedge clock);
		check(pause_seen, 1'b0);
		@(negedge clock);
		check(pause_seen, 1'b1);
		wait_idle();
		@(negedge clock);
		check(cts, 1'b0);
		@(negedge clock);
		check(cts, 1'b1);
		cfg.tx_delay_ms = 16'h0000;
		cfg.pause_chars = 8'h05;
		$display("delay test done");
		// radio stalls so the buffer only fills
		radio_take = 1'b0;
		cfg.cts_mode = flow_pkg::CTS_BUFFER;
		for (int m = 0; m < 1024; m++) begin
			term.send(m[7:0], 1'b0, 1'b0);
			if (m == 958) check(cts, 1);
			if (m == 959) begin
				// cts is registered: it drops one cycle after the write
				@(negedge clock);
				check(cts, 1'b0);
			end
		end
		check(buf_level, 16'h0400);
		check({preamble, radio_valid}, 16'h0001);
		term.send(8'hEE, 1'b0, 1'b0);
		check(ovf_cnt, 1);
		check({preamble, buf_level}, 16'h0800);
		radio_take = 1'b1;
		wait_idle();
		$display("buffer test done");
		dtr_pin = 1'b0;
		repeat (4) @(negedge clock);
		check({dsr, tx_on}, 0);
		dtr_pin = 1'b1;
		repeat (6) @(negedge clock);
		check(dsr, 1);
		$display("power test done");
		conclude();
	end
endmodule
`default_nettype wire
